// >>> logic/rtpp_packer.sv
// Real-time telemetry payload packer and bit serialiser
`include "rtpp_params.svh"

module rtpp_packer
	import rtpp_pkg::*;
#(
	parameter int PAYLOAD_BYTES = `RTPP_PAYLOAD_BYTES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_ff,
	// Sampled telemetry from housekeeping logic
	input wire rtpp_sample_type sample_in,
	input wire logic sample_valid,
	// Ground-test data, from housekeeping logic
	input wire logic [PAYLOAD_BYTES*8-1:0] debug_payload,
	// Flight configuration strap, asynchronous pin
	input wire logic flight_cfg,
	// Serial payload toward the link layer
	output rtpp_bit_type payload_bit_ff,
	output rtpp_ptype_type payload_type_ff,
	input wire logic payload_ready
);

	timeunit 1ns;
	timeprecision 1ps;

	localparam int FRAME_BITS = PAYLOAD_BYTES * 8;
	localparam int IDX_W = $clog2(FRAME_BITS);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FRAME_BITS - 1);

	// Elaboration guards: every real-time field must fit in the frame,
	// and the debug path is capped at its maximum length
	if (FRAME_BITS < `RTPP_RT_BITS) begin
		$error("Payload too short for the real-time fields");
	end
	if (FRAME_BITS > `RTPP_DEBUG_MAX_BITS) begin
		$error("Payload longer than the debug maximum");
	end

////////////////////////////////////////////////////////////////////////////
// Reset release and strap synchroniser

	logic rst_meta_ff;
	logic rst_sync_ff;
	logic flight_meta_ff;
	logic flight_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Reset value is flight: a debug frame must never slip out early
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			flight_meta_ff <= 1'b1;
			flight_ff <= 1'b1;
		end else begin
			flight_meta_ff <= flight_cfg;
			flight_ff <= flight_meta_ff;
		end
	end

////////////////////////////////////////////////////////////////////////////
// Payload layout

	// Vector bit k is payload bit offset k; field LSB sits at its offset
	function automatic logic [FRAME_BITS-1:0] pack_realtime(
		input rtpp_sample_type s,
		input logic [3:0] gnd_resets
	);
		logic [FRAME_BITS-1:0] v;
		v = '0;
		for (int i = 0; i < 3; i++) begin
			v[`RTPP_OFS_CELL_V0 + i*`RTPP_FIELD_W +: 12] =
				s.cell_pair_voltage[i];
			v[`RTPP_OFS_CELL_T0 + i*`RTPP_FIELD_W +: 12] =
				s.cell_pair_temp[i];
			v[`RTPP_OFS_ANG_VEL + i*`RTPP_FIELD_W +: 12] =
				s.angular_velocity[i];
		end
		v[`RTPP_OFS_CELL_I +: 12] = s.total_cell_current;
		v[`RTPP_OFS_BOARD_T +: 12] = s.cell_board_temp;
		for (int i = 0; i < 6; i++) begin
			v[`RTPP_OFS_PANEL_V + i*`RTPP_FIELD_W +: 12] =
				s.panel_voltage[i];
			v[`RTPP_OFS_PANEL_T + i*`RTPP_FIELD_W +: 12] =
				s.panel_temp[i];
		end
		v[`RTPP_OFS_SUPPLY_T +: 12] = s.power_supply_card_temp;
		v[`RTPP_OFS_SPIN +: 12] = s.rotation_rate;
		v[`RTPP_OFS_AMP_I +: 12] = s.transmit_amplifier_current;
		v[`RTPP_OFS_TX_T +: 12] = s.transmitter_card_temp;
		v[`RTPP_OFS_RX_T +: 12] = s.receiver_card_temp;
		v[`RTPP_OFS_RX_LEVEL +: 12] = s.rx_signal_strength;
		v[`RTPP_OFS_PROC_T +: 12] = s.housekeeping_processor_temp;
		v[`RTPP_OFS_EXP4_T +: 12] = s.fourth_experiment_temp;
		v[`RTPP_OFS_SUPPLY_I +: 12] =
			s.power_supply_card_current;
		v[`RTPP_OFS_DIAG +: 32] = s.housekeeping_processor_diag;
		v[`RTPP_OFS_EXP_FAIL +: 4] = s.experiment_fail;
		v[`RTPP_OFS_BUS_FAIL +: 3] = s.bus_fail;
		v[`RTPP_OFS_GND_RESETS +: 4] = gnd_resets;
		v[`RTPP_OFS_ANTENNA] = s.receive_antenna;
		v[`RTPP_OFS_ANTENNA + 1] = s.transmit_antenna;
		// Fields end at bit 428; everything from 429 up stays zero
		return v;
	endfunction

	// Serial index to vector bit: bytes low first, bits high first
	function automatic logic [IDX_W-1:0] bit_pos(input logic [IDX_W-1:0] idx);
		return {idx[IDX_W-1:3], ~idx[2:0]};
	endfunction

////////////////////////////////////////////////////////////////////////////
// Software registers

	logic ctrl_wr;
	logic status_wr;
	logic gnd_wr;
	logic go_req;
	logic auto_en_ff;
	rtpp_ptype_type type_sel_ff;
	rtpp_ptype_type wr_type;
	rtpp_ptype_type eff_type;
	logic [3:0] gnd_resets_ff;

	// Register select, shared by every write decode
	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return addr == ofs;
	endfunction

	assign ctrl_wr = reg_wr && reg_hit(reg_addr, `RTPP_REG_CTRL);
	assign status_wr = reg_wr && reg_hit(reg_addr, `RTPP_REG_STATUS);
	assign gnd_wr = reg_wr && reg_hit(reg_addr, `RTPP_REG_GND_RESETS);
	assign go_req = ctrl_wr && reg_wdata[`RTPP_CTRL_GO_BIT];
	assign wr_type =
		rtpp_ptype_type'(reg_wdata[`RTPP_CTRL_TYPE_LSB +: 2]);
	// A go written together with a type starts a frame of that type
	assign eff_type = ctrl_wr ? wr_type : type_sel_ff;

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			type_sel_ff <=
				rtpp_ptype_type'(2'(`RTPP_CTRL_RESET >> 1));
		end else if (ctrl_wr) begin
			type_sel_ff <= wr_type;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			auto_en_ff <= 1'b0;
		end else if (ctrl_wr) begin
			auto_en_ff <= reg_wdata[`RTPP_CTRL_AUTO_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			gnd_resets_ff <= 4'h0;
		end else if (gnd_wr) begin
			gnd_resets_ff <= reg_wdata[3:0];
		end
	end

////////////////////////////////////////////////////////////////////////////
// Sample hold and start decision

	rtpp_sample_type sample_ff;
	rtpp_sample_type sample_src;
	rtpp_state_type state_ff;
	logic start_req;
	logic start_ok;
	logic start_inhibit;
	logic start_badtype;
	logic start_drop;

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff)
			sample_ff <= '0;
		else if (sample_valid)
			sample_ff <= sample_in;
	end

	// A sample arriving with the start is used at once
	assign sample_src = sample_valid ? sample_in : sample_ff;
	assign start_req = go_req || (auto_en_ff && sample_valid);
	assign start_drop = start_req && (state_ff == RTPP_SEND);
	assign start_inhibit = start_req && (state_ff == RTPP_IDLE) &&
		(eff_type == RTPP_TYPE_DEBUG) && flight_ff;
	assign start_badtype = start_req && (state_ff == RTPP_IDLE) &&
		(eff_type != RTPP_TYPE_DEBUG) &&
		(eff_type != RTPP_TYPE_REALTIME);
	assign start_ok = start_req && (state_ff == RTPP_IDLE) &&
		!start_inhibit && !start_badtype;

////////////////////////////////////////////////////////////////////////////
// Serialiser

	logic [FRAME_BITS-1:0] frame_ff;
	logic [FRAME_BITS-1:0] nxt_frame;
	logic [IDX_W-1:0] idx_ff;
	logic [IDX_W-1:0] nxt_idx;
	logic bit_taken;

	logic send_step;
	logic send_done;

	assign nxt_frame = (eff_type == RTPP_TYPE_DEBUG) ? debug_payload :
		pack_realtime(sample_src, gnd_resets_ff);
	assign bit_taken = payload_bit_ff.valid && payload_ready;
	assign nxt_idx = idx_ff + 1'b1;
	// The link layer takes a bit; taking the final one closes the frame
	assign send_step = (state_ff == RTPP_SEND) && bit_taken &&
		(idx_ff != LAST_IDX);
	assign send_done = (state_ff == RTPP_SEND) && bit_taken &&
		(idx_ff == LAST_IDX);

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= RTPP_IDLE;
		end else begin
			unique case (state_ff)
				RTPP_IDLE: begin
					if (start_ok) begin
						state_ff <= RTPP_SEND;
					end
				end
				RTPP_SEND: begin
					if (send_done) begin
						state_ff <= RTPP_IDLE;
					end
				end
			endcase
		end
	end

	// Image taken once at the start so later samples cannot tear it
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			frame_ff <= '0;
		end else if (start_ok) begin
			frame_ff <= nxt_frame;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			idx_ff <= '0;
		end else if (start_ok) begin
			idx_ff <= '0;
		end else if (send_step) begin
			idx_ff <= nxt_idx;
		end
	end

	// A bit stands until taken; valid drops the cycle after the last one
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			payload_bit_ff <= '0;
		end else if (start_ok) begin
			payload_bit_ff.valid <= 1'b1;
			payload_bit_ff.first <= 1'b1;
			payload_bit_ff.last <= 1'b0;
			payload_bit_ff.data <= nxt_frame[bit_pos('0)];
		end else if (send_step) begin
			payload_bit_ff.first <= 1'b0;
			payload_bit_ff.last <= (nxt_idx == LAST_IDX);
			payload_bit_ff.data <= frame_ff[bit_pos(nxt_idx)];
		end else if (send_done) begin
			payload_bit_ff <= '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			payload_type_ff <= RTPP_TYPE_REALTIME;
		end else if (start_ok) begin
			payload_type_ff <= eff_type;
		end
	end

////////////////////////////////////////////////////////////////////////////
// Status flags and frame counter

	logic inhibit_ff;
	logic badtype_ff;
	logic drop_ff;
	logic [15:0] frames_ff;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			inhibit_ff <= 1'b0;
		end else begin
			inhibit_ff <= start_inhibit || (inhibit_ff &&
				!(status_wr && reg_wdata[`RTPP_ST_INHIBIT_BIT]));
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			badtype_ff <= 1'b0;
		end else begin
			badtype_ff <= start_badtype || (badtype_ff &&
				!(status_wr && reg_wdata[`RTPP_ST_BADTYPE_BIT]));
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			drop_ff <= 1'b0;
		end else begin
			drop_ff <= start_drop || (drop_ff &&
				!(status_wr && reg_wdata[`RTPP_ST_DROP_BIT]));
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff)
			frames_ff <= 16'h0000;
		else if (bit_taken && payload_bit_ff.last)
			frames_ff <= frames_ff + 16'h0001;
	end

////////////////////////////////////////////////////////////////////////////
// Read port

	logic [31:0] status_word;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`RTPP_ST_BUSY_BIT] = (state_ff == RTPP_SEND);
		status_word[`RTPP_ST_INHIBIT_BIT] = inhibit_ff;
		status_word[`RTPP_ST_BADTYPE_BIT] = badtype_ff;
		status_word[`RTPP_ST_DROP_BIT] = drop_ff;
		status_word[`RTPP_ST_FLIGHT_BIT] = flight_ff;
	end

	// Data stand only in the cycle after the strobe; unmapped read zero
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			reg_rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`RTPP_REG_CTRL: reg_rdata_ff <= {28'h000_0000, auto_en_ff,
					type_sel_ff, 1'b0};
				`RTPP_REG_STATUS: reg_rdata_ff <= status_word;
				`RTPP_REG_FRAMES: reg_rdata_ff <= {16'h0000, frames_ff};
				`RTPP_REG_GND_RESETS: reg_rdata_ff <= {28'h000_0000,
					gnd_resets_ff};
				default: reg_rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_ff <= 32'h0000_0000;
		end
	end

endmodule

// >>> logic/rtpp_params.svh
// Constants of the real-time telemetry payload packer
`ifndef RTPP_PARAMS_SVH
`define RTPP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Payload sizes
`define RTPP_PAYLOAD_BYTES 58
`define RTPP_RT_BITS 429
`define RTPP_DEBUG_MAX_BITS 464
`define RTPP_FIELD_W 12

////////////////////////////////////////////////////////////////////////////
// Field offsets
`define RTPP_OFS_CELL_V0 0
`define RTPP_OFS_CELL_V1 12
`define RTPP_OFS_CELL_V2 24
`define RTPP_OFS_CELL_T0 36
`define RTPP_OFS_CELL_T1 48
`define RTPP_OFS_CELL_T2 60
`define RTPP_OFS_CELL_I 72
`define RTPP_OFS_BOARD_T 84
`define RTPP_OFS_PANEL_V 96
`define RTPP_OFS_PANEL_T 168
`define RTPP_OFS_SUPPLY_T 240
`define RTPP_OFS_SPIN 252
`define RTPP_OFS_AMP_I 264
`define RTPP_OFS_TX_T 276
`define RTPP_OFS_RX_T 288
`define RTPP_OFS_RX_LEVEL 300
`define RTPP_OFS_PROC_T 312
`define RTPP_OFS_ANG_VEL 324
`define RTPP_OFS_EXP4_T 360
`define RTPP_OFS_SUPPLY_I 372
`define RTPP_OFS_DIAG 384
`define RTPP_OFS_EXP_FAIL 416
`define RTPP_OFS_BUS_FAIL 420
`define RTPP_OFS_GND_RESETS 423
`define RTPP_OFS_ANTENNA 427

////////////////////////////////////////////////////////////////////////////
// Register map, byte addresses
`define RTPP_REG_CTRL 8'h00
`define RTPP_REG_STATUS 8'h04
`define RTPP_REG_FRAMES 8'h08
`define RTPP_REG_GND_RESETS 8'h0C

// Control fields
`define RTPP_CTRL_GO_BIT 0
`define RTPP_CTRL_TYPE_LSB 1
`define RTPP_CTRL_AUTO_BIT 3
`define RTPP_CTRL_RESET 4'h2

// Status fields
`define RTPP_ST_BUSY_BIT 0
`define RTPP_ST_INHIBIT_BIT 1
`define RTPP_ST_BADTYPE_BIT 2
`define RTPP_ST_DROP_BIT 3
`define RTPP_ST_FLIGHT_BIT 4

`endif

// >>> logic/rtpp_pkg.sv
// Types of the real-time telemetry payload packer
package rtpp_pkg;

	typedef enum logic [1:0] {
		RTPP_TYPE_DEBUG = 2'b00,
		RTPP_TYPE_REALTIME = 2'b01,
		RTPP_TYPE_MAXIMA = 2'b10,
		RTPP_TYPE_MINIMA = 2'b11
	} rtpp_ptype_type;

	typedef enum logic [0:0] {
		RTPP_IDLE = 1'b0,
		RTPP_SEND = 1'b1
	} rtpp_state_type;

	// Panel and axis arrays are indexed +X,-X,+Y,-Y,+Z,-Z and X,Y,Z
	typedef struct packed {
		logic [2:0][11:0] cell_pair_voltage;
		logic [2:0][11:0] cell_pair_temp;
		logic [11:0] total_cell_current;
		logic [11:0] cell_board_temp;
		logic [5:0][11:0] panel_voltage;
		logic [5:0][11:0] panel_temp;
		logic [11:0] power_supply_card_temp;
		logic [11:0] rotation_rate;
		logic [11:0] transmit_amplifier_current;
		logic [11:0] transmitter_card_temp;
		logic [11:0] receiver_card_temp;
		logic [11:0] rx_signal_strength;
		logic [11:0] housekeeping_processor_temp;
		logic [2:0][11:0] angular_velocity;
		logic [11:0] fourth_experiment_temp;
		logic [11:0] power_supply_card_current;
		logic [31:0] housekeeping_processor_diag;
		logic [3:0] experiment_fail;
		logic [2:0] bus_fail;
		logic receive_antenna;
		logic transmit_antenna;
	} rtpp_sample_type;

	typedef struct packed {
		logic valid;
		logic data;
		logic first;
		logic last;
	} rtpp_bit_type;

endpackage

// >>> verif/rtpp_link_sink.sv
// Link layer model that accepts the serial payload
module rtpp_link_sink
	import rtpp_pkg::*;
#(
	parameter int BITS = 464
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Stream from the packer
	input wire rtpp_bit_type bit_in,
	input wire rtpp_ptype_type type_in,
	output logic ready,
	// Bench side
	input wire logic stall,
	output logic [BITS-1:0] cap,
	output rtpp_ptype_type last_type,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt;

	// Stalling halves the accept rate so every bit after the first sees a wait state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
			cnt <= 9'h000;
			frames <= 0;
			last_type <= RTPP_TYPE_REALTIME;
		end else begin
			ready <= stall ? ~ready : 1'b1;
			if (bit_in.valid && ready) begin
				cap[{cnt[8:3], ~cnt[2:0]}] <= bit_in.data;
				cnt <= bit_in.last ? 9'h000 : cnt + 9'h001;
				if (bit_in.last) begin
					frames <= frames + 1;
					last_type <= type_in;
				end
			end
		end
	end
endmodule

// >>> verif/rtpp_packer_properties.sv
// Concurrent checks on the payload packer ports
module rtpp_packer_properties
	import rtpp_pkg::*;
#(
	parameter int PAYLOAD_BYTES = 58
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata_ff,
	// Strap and stream
	input wire logic flight_cfg,
	input wire rtpp_bit_type payload_bit_ff,
	input wire rtpp_ptype_type payload_type_ff,
	input wire logic payload_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LAST_IDX = PAYLOAD_BYTES * 8 - 1;
	logic [8:0] cnt_ff;
	logic [8:0] vec_idx;
	logic taken;
	assign taken = payload_bit_ff.valid && payload_ready;
	assign vec_idx = {cnt_ff[8:3], ~cnt_ff[2:0]};

	// Serial position within the frame, counted on accepted bits only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 9'h000;
		end else if (taken) begin
			cnt_ff <= payload_bit_ff.last ? 9'h000 : cnt_ff + 9'h001;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata_ff == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read answer");
	property p_hold;
		payload_bit_ff.valid && !payload_ready |=>
			$stable(payload_bit_ff) && $stable(payload_type_ff);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stream bit changed while stalled");
	property p_first_pos;
		payload_bit_ff.valid |-> payload_bit_ff.first == (cnt_ff == 9'h000);
	endproperty
	a_first_pos: assert property (p_first_pos)
		else $error("first flag off frame start");
	property p_last_pos;
		payload_bit_ff.valid |->
			payload_bit_ff.last == (cnt_ff == 9'(LAST_IDX));
	endproperty
	a_last_pos: assert property (p_last_pos)
		else $error("last flag not at final padded bit");
	property p_pad_zero;
		payload_bit_ff.valid && payload_type_ff == RTPP_TYPE_REALTIME &&
			vec_idx >= 9'h1AD |-> !payload_bit_ff.data;
	endproperty
	a_pad_zero: assert property (p_pad_zero)
		else $error("padding bit not zero");
	property p_frame_start;
		$rose(payload_bit_ff.valid) |-> payload_bit_ff.first;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("frame began without first flag");
	property p_frame_end;
		taken && payload_bit_ff.last |=> !payload_bit_ff.valid;
	endproperty
	a_frame_end: assert property (p_frame_end)
		else $error("stream ran past the final bit");
	property p_no_debug_flight;
		$rose(payload_bit_ff.valid) && payload_type_ff == RTPP_TYPE_DEBUG
			|-> !$past(flight_cfg, 3);
	endproperty
	a_no_debug_flight: assert property (p_no_debug_flight)
		else $error("debug frame sent in flight");

	c_rt: cover property ($rose(payload_bit_ff.valid) &&
		payload_type_ff == RTPP_TYPE_REALTIME);
	c_dbg: cover property ($rose(payload_bit_ff.valid) &&
		payload_type_ff == RTPP_TYPE_DEBUG);
	c_stall: cover property (payload_bit_ff.valid && !payload_ready);
endmodule

bind rtpp_packer rtpp_packer_properties #(
	.PAYLOAD_BYTES(PAYLOAD_BYTES)
) u_props (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.reg_rd(reg_rd),
	.reg_rdata_ff(reg_rdata_ff),
	.flight_cfg(flight_cfg),
	.payload_bit_ff(payload_bit_ff),
	.payload_type_ff(payload_type_ff),
	.payload_ready(payload_ready)
);

// >>> verif/tb_top.sv
// Self-checking bench for the payload packer
`include "rtpp_params.svh"
module tb_top
	import rtpp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sample_valid = 1'b0;
	logic flight_cfg = 1'b1;
	logic stall = 1'b0;
	rtpp_sample_type sample_in = '0;
	logic [463:0] debug_payload = 464'({15{32'hC3A5_1E87}});
	logic [31:0] reg_rdata_ff;
	rtpp_bit_type payload_bit_ff;
	rtpp_ptype_type payload_type_ff;
	rtpp_ptype_type last_type;
	logic payload_ready;
	logic [463:0] cap;
	rtpp_sample_type s1;
	int frames;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;

	rtpp_packer u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .sample_in(sample_in),
		.sample_valid(sample_valid), .debug_payload(debug_payload),
		.flight_cfg(flight_cfg), .payload_bit_ff(payload_bit_ff),
		.payload_type_ff(payload_type_ff), .payload_ready(payload_ready));
	rtpp_link_sink u_sink (.clk(ref_clk), .rst_n(rst_n),
		.bit_in(payload_bit_ff), .type_in(payload_type_ff),
		.ready(payload_ready), .stall(stall), .cap(cap),
		.last_type(last_type), .frames(frames));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_vec(input logic [463:0] got, input logic [463:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t payload got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk_word(reg_rdata_ff, exp);
	endtask
	task automatic wait_frames(input int n);
		for (int i = 0; i < 3000 && frames < n; i++) begin
			@(posedge ref_clk);
		end
		chk_word(32'(frames), 32'(n));
	endtask
	task automatic send_sample(input rtpp_sample_type s);
		@(posedge ref_clk);
		sample_in <= s;
		sample_valid <= 1'b1;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
	endtask
	// Reference layout built field by field, field LSB at its offset
	function automatic logic [463:0] exp_rt(rtpp_sample_type s, logic [3:0] g);
		logic [463:0] v;
		v = '0;
		for (int i = 0; i < 3; i++) begin
			v[i*12 +: 12] = s.cell_pair_voltage[i];
			v[36+i*12 +: 12] = s.cell_pair_temp[i];
			v[324+i*12 +: 12] = s.angular_velocity[i];
		end
		for (int i = 0; i < 6; i++) begin
			v[96+i*12 +: 12] = s.panel_voltage[i];
			v[168+i*12 +: 12] = s.panel_temp[i];
		end
		v[72 +: 12] = s.total_cell_current;
		v[84 +: 12] = s.cell_board_temp;
		v[240 +: 12] = s.power_supply_card_temp;
		v[252 +: 12] = s.rotation_rate;
		v[264 +: 12] = s.transmit_amplifier_current;
		v[276 +: 12] = s.transmitter_card_temp;
		v[288 +: 12] = s.receiver_card_temp;
		v[300 +: 12] = s.rx_signal_strength;
		v[312 +: 12] = s.housekeeping_processor_temp;
		v[360 +: 12] = s.fourth_experiment_temp;
		v[372 +: 12] = s.power_supply_card_current;
		v[384 +: 32] = s.housekeeping_processor_diag;
		v[416 +: 4] = s.experiment_fail;
		v[420 +: 3] = s.bus_fail;
		v[423 +: 4] = g;
		v[427] = s.receive_antenna;
		v[428] = s.transmit_antenna;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(`RTPP_REG_CTRL, 32'h2);
		rd(`RTPP_REG_STATUS, 32'h10);
		wr(8'h10, 32'hF);
		rd(8'h10, 32'h0);
		wr(`RTPP_REG_GND_RESETS, 32'hFA);
		rd(`RTPP_REG_GND_RESETS, 32'hA);
		rd(`RTPP_REG_FRAMES, 32'h0);
	endtask
	// Stalled link, plus a second go while busy that must be dropped
	task automatic t_realtime();
		s1 = rtpp_sample_type'(425'({14{32'h9E37_79B9}}));
		send_sample(s1);
		stall <= 1'b1;
		wr(`RTPP_REG_CTRL, 32'h3);
		wr(`RTPP_REG_CTRL, 32'h3);
		wait_frames(1);
		chk_vec(cap, exp_rt(s1, 4'hA));
		chk_word(32'(last_type), 32'h1);
		rd(`RTPP_REG_FRAMES, 32'h1);
		rd(`RTPP_REG_STATUS, 32'h18);
		wr(`RTPP_REG_STATUS, 32'h8);
		rd(`RTPP_REG_STATUS, 32'h10);
	endtask
	task automatic t_auto();
		@(posedge ref_clk);
		stall <= 1'b0;
		wr(`RTPP_REG_CTRL, 32'hA);
		send_sample(rtpp_sample_type'(~s1));
		wait_frames(2);
		chk_vec(cap, exp_rt(rtpp_sample_type'(~s1), 4'hA));
		wr(`RTPP_REG_CTRL, 32'h2);
	endtask
	task automatic t_inhibit();
		wr(`RTPP_REG_CTRL, 32'h1);
		repeat (40) @(posedge ref_clk);
		chk_word(32'(frames), 32'h2);
		rd(`RTPP_REG_STATUS, 32'h12);
		for (int t = 2; t < 4; t++) begin
			wr(`RTPP_REG_CTRL, 32'((t << 1) | 1));
		end
		repeat (40) @(posedge ref_clk);
		chk_word(32'(frames), 32'h2);
		rd(`RTPP_REG_STATUS, 32'h16);
		wr(`RTPP_REG_STATUS, 32'hE);
		rd(`RTPP_REG_STATUS, 32'h10);
	endtask
	task automatic t_ground();
		@(posedge ref_clk);
		flight_cfg <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rd(`RTPP_REG_STATUS, 32'h0);
		wr(`RTPP_REG_CTRL, 32'h1);
		wait_frames(3);
		chk_vec(cap, debug_payload);
		chk_word(32'(last_type), 32'h0);
		flight_cfg <= 1'b1;
	endtask

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Whole run needs a few thousand cycles; this ceiling only cuts hangs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("MISMATCH %0t run did not finish", $time);
			conclude();
		end
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs();
		t_realtime();
		t_auto();
		t_inhibit();
		t_ground();
		conclude();
	end
endmodule
